//--- rtl/i2cst_slave_tx.sv
/*
  I2C slave-transmit path with its register port, event flags and interrupt.
  Assumes SCL/SDA arrive asynchronously, open-drain resolved outside, and a
  register master that issues one-cycle strobes on clk_i.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module i2cst_slave_tx
  import i2cst_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o
);

  i2cst_st_s r;
  i2cst_st_s n;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_det;
  logic      stop_det;
  logic      busy;
  logic [3:0] cnt_inc;
  logic [7:0] stat;

  function automatic logic hit(input logic acc, input logic [2:0] a,
                               input logic [2:0] k);
    return acc && (a == k);
  endfunction

  // Edges from the second and third flops only
  assign scl_rise  = r.scl2 & ~r.scl3;
  assign scl_fall  = ~r.scl2 & r.scl3;
  assign start_det = r.scl2 & r.scl3 & ~r.sda2 & r.sda3;
  assign stop_det  = r.scl2 & r.scl3 & r.sda2 & ~r.sda3;
  // Stretching counts as idle so software can load the next byte
  assign busy      = !(r.st == S_IDLE || r.st == S_HOLD);
  assign cnt_inc   = r.cnt + 4'h1;

  always_comb begin
    n      = r;
    stat   = 8'h00;
    stat[ST_BF]    = r.bf;
    stat[ST_RW]    = r.rw;
    stat[ST_START] = r.start;
    stat[ST_STOP]  = r.stop;
    n.rdata = 8'h00;
    n.scl1  = scl_i;
    n.scl2  = r.scl1;
    n.scl3  = r.scl2;
    n.sda1  = sda_i;
    n.sda2  = r.sda1;
    n.sda3  = r.sda2;

    if (hit(rd_i, addr_i, A_BUF)) begin
      n.rdata = r.sbuf;
      n.bf    = 1'b0;
    end else if (hit(rd_i, addr_i, A_STAT)) begin
      n.rdata = stat;
    end else if (hit(rd_i, addr_i, A_CON1)) begin
      n.rdata = r.con1;
    end else if (hit(rd_i, addr_i, A_CON2)) begin
      n.rdata = r.con2;
    end else if (hit(rd_i, addr_i, A_CON3)) begin
      n.rdata = r.con3;
    end else if (hit(rd_i, addr_i, A_OWN)) begin
      n.rdata = {1'b0, r.own};
    end else if (hit(rd_i, addr_i, A_EVT)) begin
      n.rdata = {5'h00, r.ev};
      n.ev    = 3'h0;
    end else if (hit(rd_i, addr_i, A_MASK)) begin
      n.rdata = {5'h00, r.mask};
    end

    if (hit(wr_i, addr_i, A_BUF)) begin
      if (!busy) begin
        n.sbuf = wdata_i;
        n.sr   = wdata_i;
        n.bf   = 1'b1;
      end
    end else if (hit(wr_i, addr_i, A_CON1)) begin
      n.con1 = wdata_i;
    end else if (hit(wr_i, addr_i, A_CON2)) begin
      n.con2[C2_GENERAL_CALL_ENABLE]  = wdata_i[C2_GENERAL_CALL_ENABLE];
      n.con2[C2_ACK_VALUE_BIT] = wdata_i[C2_ACK_VALUE_BIT];
      // Busy: sequence bits may only be cleared, never set
      n.con2 = busy ? (n.con2 & ~(C2_SEQ & ~wdata_i))
                    : ((n.con2 & ~C2_SEQ) | (wdata_i & C2_SEQ));
    end else if (hit(wr_i, addr_i, A_CON3)) begin
      n.con3 = wdata_i;
    end else if (hit(wr_i, addr_i, A_OWN)) begin
      n.own = wdata_i[6:0];
    end else if (hit(wr_i, addr_i, A_MASK)) begin
      n.mask = wdata_i[2:0];
    end

    // Link side; hardware sets come last so they win over clears
    if (start_det) begin
      n.start    = 1'b1;
      n.stop     = 1'b0;
      n.rw       = 1'b0;
      n.st       = S_ADDR;
      n.cnt      = 4'h0;
      n.scl_oe_n = 1'b1;
      n.sda_oe_n = 1'b1;
      if (r.con3[C3_SCIE]) begin
        n.ev[EV_SSP] = 1'b1;
      end
    end else if (stop_det) begin
      n.stop     = 1'b1;
      n.start    = 1'b0;
      n.rw       = 1'b0;
      n.st       = S_IDLE;
      n.scl_oe_n = 1'b1;
      n.sda_oe_n = 1'b1;
    end else begin
      case (r.st)
        S_IDLE: begin
          n.st = S_IDLE;
        end
        S_ADDR: begin
          if (scl_rise) begin
            n.sr  = {r.sr[6:0], r.sda2};
            n.cnt = cnt_inc;
          end else if (scl_fall && r.cnt == BITS) begin
            if (r.sr[7:1] == r.own && r.sr[0]) begin
              n.sda_oe_n = 1'b0;
              n.st       = S_AACK;
            end else begin
              // Only read requests are served; anything else is let go
              if (r.sr[7:1] == GC_ADDR && !r.sr[0] && r.con2[C2_GENERAL_CALL_ENABLE]) begin
                n.ev[EV_GC] = 1'b1;
              end
              n.st = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            n.sda_oe_n     = 1'b1;
            n.scl_oe_n     = 1'b0;
            n.con1[C1_CKP] = 1'b0;
            n.rw           = 1'b1;
            n.sbuf         = r.sr;
            n.bf           = 1'b1;
            n.ev[EV_SSP]   = 1'b1;
            n.st           = S_HOLD;
          end
        end
        S_HOLD: begin
          // SCL stays low until software sets clock_release
          if (r.con1[C1_CKP]) begin
            n.scl_oe_n = 1'b1;
            n.sda_oe_n = r.sr[7];
            n.cnt      = 4'h0;
            n.st       = S_TX;
          end
        end
        S_TX: begin
          // Released one bit read back low: someone else owns SDA
          if (scl_rise && r.sda_oe_n && !r.sda2 && r.con3[C3_SLAVE_COLLISION_DETECT_ENABLE]) begin
            n.ev[EV_BCL] = 1'b1;
            n.sda_oe_n   = 1'b1;
            n.rw         = 1'b0;
            n.st         = S_IDLE;
          end else if (scl_fall) begin
            n.cnt = cnt_inc;
            if (cnt_inc == BITS) begin
              n.sda_oe_n = 1'b1;
              n.bf       = 1'b0;
              n.st       = S_TACK;
            end else begin
              n.sr       = {r.sr[6:0], 1'b0};
              n.sda_oe_n = r.sr[6];
            end
          end
        end
        S_TACK: begin
          // Only the ninth rising edge updates the ack status
          if (scl_rise) begin
            n.con2[C2_ACKST] = r.sda2;
          end else if (scl_fall) begin
            n.ev[EV_SSP] = 1'b1;
            if (r.con2[C2_ACKST]) begin
              n.rw = 1'b0;
              n.st = S_IDLE;
            end else begin
              n.scl_oe_n     = 1'b0;
              n.con1[C1_CKP] = 1'b0;
              n.st           = S_HOLD;
            end
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end
    n.irq = |(n.ev & n.mask);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // Open drain: value fixed low, the enables carry the data
  assign rdata_o    = r.rdata;
  assign irq_o      = r.irq;
  assign scl_o      = r.lo;
  assign sda_o      = r.lo;
  assign scl_oe_n_o = r.scl_oe_n;
  assign sda_oe_n_o = r.sda_oe_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  chk_addr_ack: assert property (
    r.st == S_ADDR && scl_fall && r.cnt == BITS && r.sr[7:1] == r.own && r.sr[0]
    && !start_det && !stop_det |=> !sda_oe_n_o && r.st == S_AACK)
    else $error("read address not acknowledged");

  chk_stretch_hold: assert property (
    r.st == S_AACK && scl_fall && !start_det && !stop_det
    |=> !scl_oe_n_o && !r.con1[C1_CKP] && r.rw && r.bf && r.ev[EV_SSP])
    else $error("clock not stretched after read address");

  chk_buf_load: assert property (
    hit(wr_i, addr_i, A_BUF) && !busy |=> r.sr == $past(wdata_i))
    else $error("buffer write did not load shift register");

  chk_sda_stable: assert property (
    r.st == S_TX && r.scl2 && r.scl3 && $past(r.st) == S_TX |-> $stable(sda_oe_n_o))
    else $error("data changed while clock high");

  chk_ack_latch: assert property (
    r.st == S_TACK && scl_rise && !start_det && !stop_det
    |=> r.con2[C2_ACKST] == $past(r.sda2))
    else $error("acknowledge not latched on rising edge");

  chk_nack_idle: assert property (
    r.st == S_TACK && scl_fall && r.con2[C2_ACKST] && !start_det && !stop_det
    |=> r.st == S_IDLE && scl_oe_n_o && r.ev[EV_SSP])
    else $error("not-acknowledge did not end transfer");

  chk_ack_stretch: assert property (
    r.st == S_TACK && scl_fall && !r.con2[C2_ACKST] && !start_det && !stop_det
    |=> !scl_oe_n_o [*2])
    else $error("clock not stretched after acknowledge");

  chk_collision: assert property (
    r.st == S_TX && scl_rise && r.sda_oe_n && !r.sda2 && r.con3[C3_SLAVE_COLLISION_DETECT_ENABLE]
    && !start_det && !stop_det |=> r.st == S_IDLE && r.ev[EV_BCL])
    else $error("collision not handled");

  chk_start_flag: assert property (
    start_det |=> r.start && r.st == S_ADDR && sda_oe_n_o)
    else $error("start not recorded");

  chk_buf_clear: assert property (
    hit(rd_i, addr_i, A_BUF) && !(r.st == S_AACK && scl_fall) |=> !r.bf)
    else $error("buffer read did not clear full flag");

  chk_stop_idle: assert property (
    stop_det |=> r.st == S_IDLE && sda_oe_n_o && scl_oe_n_o)
    else $error("stop did not release the bus");

  chk_seq_refuse: assert property (
    busy && hit(wr_i, addr_i, A_CON2)
    |=> (r.con2 & C2_SEQ & ~$past(r.con2)) == 8'h00)
    else $error("sequence bit set while busy");

  chk_ninth_release: assert property (
    r.st == S_TACK |-> sda_oe_n_o)
    else $error("data line driven during acknowledge clock");

  // Link checks leave out a same-cycle Start or Stop,
  // which overrides whatever the state machine would do
  chk_shift_bit: assert property (
    r.st == S_TX && scl_fall && cnt_inc != BITS && !start_det && !stop_det
    |=> sda_oe_n_o == $past(r.sr[6]))
    else $error("data bit not shifted on falling clock");

  chk_hold_release: assert property (
    r.st == S_HOLD && r.con1[C1_CKP] && !start_det && !stop_det
    |=> scl_oe_n_o && r.st == S_TX && sda_oe_n_o == $past(r.sr[7]))
    else $error("clock release did not start the byte");

  chk_event_ninth: assert property (
    r.st == S_TACK && scl_fall && !start_det && !stop_det |=> r.ev[EV_SSP])
    else $error("event flag not set on ninth falling clock");

  chk_start_event: assert property (
    start_det && r.con3[C3_SCIE] |=> r.ev[EV_SSP])
    else $error("start event flag not set");

  chk_stop_flag: assert property (
    stop_det |=> r.stop && !r.start && !r.rw)
    else $error("stop not recorded");

  chk_gc_flag: assert property (
    r.st == S_ADDR && scl_fall && r.cnt == BITS && r.sr == {GC_ADDR, 1'b0}
    && r.con2[C2_GENERAL_CALL_ENABLE] && !start_det && !stop_det |=> r.ev[EV_GC] && sda_oe_n_o)
    else $error("general call not flagged");

  chk_gc_ignored: assert property (
    r.st == S_ADDR && scl_fall && r.cnt == BITS && r.sr == {GC_ADDR, 1'b0}
    && !r.con2[C2_GENERAL_CALL_ENABLE] && !r.ev[EV_GC] && !start_det && !stop_det |=> !r.ev[EV_GC])
    else $error("general call flagged while disabled");

  cov_read_addr: cover property (r.st == S_AACK ##1 r.st == S_HOLD);
  cov_byte_acked: cover property (r.st == S_TACK ##1 r.st == S_HOLD);
  cov_byte_nacked: cover property (r.st == S_TACK ##1 r.st == S_IDLE);
  cov_collision: cover property ($rose(r.ev[EV_BCL]));
  cov_general_call: cover property ($rose(r.ev[EV_GC]));

endmodule // i2cst_slave_tx

//--- rtl/i2cst_pkg.sv
/*
  Constants, register map and state types for the I2C slave-transmit block.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package i2cst_pkg;
  // Register offsets
  localparam logic [2:0] A_BUF  = 3'h0;
  localparam logic [2:0] A_STAT = 3'h1;
  localparam logic [2:0] A_CON1 = 3'h2;
  localparam logic [2:0] A_CON2 = 3'h3;
  localparam logic [2:0] A_CON3 = 3'h4;
  localparam logic [2:0] A_OWN  = 3'h5;
  localparam logic [2:0] A_EVT  = 3'h6;
  localparam logic [2:0] A_MASK = 3'h7;
  // serial_status_reg fields
  localparam int ST_BF    = 0;
  localparam int ST_RW    = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP  = 4;
  // serial_control_one / three fields
  localparam int C1_CKP   = 4;
  localparam int C3_SLAVE_COLLISION_DETECT_ENABLE = 2;
  localparam int C3_SCIE  = 5;
  // serial_control_two fields
  localparam int C2_GENERAL_CALL_ENABLE  = 7;
  localparam int C2_ACKST = 6;
  localparam int C2_ACK_VALUE_BIT = 5;
  localparam logic [7:0] C2_SEQ = 8'h1f;
  // Event status / mask fields, bits per byte and general-call address
  localparam int EV_SSP = 0;
  localparam int EV_BCL = 1;
  localparam int EV_GC  = 2;
  localparam logic [3:0] BITS    = 4'h8;
  localparam logic [6:0] GC_ADDR = 7'h00;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_HOLD = 3'b011,
    S_TX   = 3'b100,
    S_TACK = 3'b101
  } i2cst_state_e;

  typedef struct packed {
    i2cst_state_e st;
    logic [3:0]   cnt;
    logic [7:0]   sr;
    logic [7:0]   sbuf;
    logic         bf;
    logic         rw;
    logic         start;
    logic         stop;
    logic [7:0]   con1;
    logic [7:0]   con2;
    logic [7:0]   con3;
    logic [6:0]   own;
    logic [2:0]   ev;
    logic [2:0]   mask;
    logic [7:0]   rdata;
    logic         irq;
    logic         scl1;
    logic         scl2;
    logic         scl3;
    logic         sda1;
    logic         sda2;
    logic         sda3;
    logic         scl_oe_n;
    logic         sda_oe_n;
    logic         lo;
  } i2cst_st_s;

  // Synchronisers start at the idle bus level so release shows no false edge
  localparam i2cst_st_s ST_RST = '{st: S_IDLE, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
                                   scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
                                   sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
                                   default: '0};
endpackage

//--- verification/i2cst_master_model.sv
/*
  Behavioural I2C bus master for the slave-transmit block.
  Assumes the bench resolves open-drain lines with pull-ups: 1 = release.
*/
`timescale 1ns/100ps
module i2cst_master_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One SCL pulse: data set in low phase, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    int n;
    n = 0;
    #20 sda_o = b;
    #60 scl_o = 1'b1;
    // Slave may stretch; wait for the line itself
    while (scl_i !== 1'b1 && n < 100000) begin
      #8 n = n + 1;
    end
    #40 s = sda_i;
    #40 scl_o = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_drv,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_drv, ack);
  endtask

  // Start or repeated start, leaves SCL low
  task automatic start();
    sda_o = 1'b1;
    #40 scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #40 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #80;
  endtask
endmodule // i2cst_master_model

//--- verification/i2c_slave_transmit_tb.sv
/*
  Self-checking bench for the I2C slave-transmit block.
  Assumes pull-ups on both lines and the master model on the far side.
*/
`timescale 1ns/100ps
module i2c_slave_transmit_tb;
  import i2cst_pkg::*;
  typedef struct packed {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] q;
  } i2cst_row_s;
  logic       clk_i, reset_i, wr_s, rd_s, irq, ack;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, v, rx;
  int         n_fail = 0;
  int         comparisons = 0;
  wire        scl_w = m_scl & (scl_oe_n | scl_o);
  wire        sda_w = m_sda & (sda_oe_n | sda_o);
  i2cst_row_s rows [6] = '{'{A_CON1, 8'ha5, 8'ha5}, '{A_CON3, 8'h5a, 8'h5a},
    '{A_OWN, 8'hff, 8'h7f}, '{A_MASK, 8'hff, 8'h07}, '{A_CON2, 8'hff, 8'hbf},
    '{A_CON2, 8'h00, 8'h00}};

  i2cst_slave_tx i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
  i2cst_master_model i_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
    .sda_o(m_sda));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_i);
    wr_s  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle();
    repeat (5) @(posedge clk_i);
  endtask

  task automatic final_report();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    // Several times the expected run length
    #100000;
    n_fail++;
    final_report();
  end

  initial begin
    reset_i = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    for (int i = 0; i < 8; i++) rdchk(3'(i), 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].q);
    end
    wr(A_OWN, 8'h2a);
    wr(A_MASK, 8'h07);
    wr(A_CON3, 8'h24);
    #3 i_mst.start();
    rdchk(A_STAT, 8'h08);
    rdchk(A_EVT, 8'h01);
    // Writes while the address is still shifting in
    fork
      i_mst.xfer(8'h55, 1'b1, rx, ack);
      begin
        repeat (60) @(posedge clk_i);
        wr(A_BUF, 8'h77);
        wr(A_CON2, 8'h1f);
      end
    join
    settle();
    chk({7'h0, ack}, 8'h00);
    chk({7'h0, scl_oe_n}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    wr(A_MASK, 8'h00);
    settle();
    chk({7'h0, irq}, 8'h00);
    wr(A_MASK, 8'h07);
    rdchk(A_STAT, 8'h0d);
    rdchk(A_EVT, 8'h01);
    rdchk(A_CON2, 8'h00);
    rdchk(A_BUF, 8'h55);
    rdchk(A_STAT, 8'h0c);
    wr(A_BUF, 8'hc3);
    wr(A_CON1, 8'h10);
    i_mst.xfer(8'hff, 1'b0, rx, ack);
    chk(rx, 8'hc3);
    settle();
    chk({7'h0, scl_oe_n}, 8'h00);
    rdchk(A_CON2, 8'h00);
    rdchk(A_EVT, 8'h01);
    wr(A_BUF, 8'h3c);
    wr(A_CON1, 8'h10);
    i_mst.xfer(8'hff, 1'b1, rx, ack);
    chk(rx, 8'h3c);
    chk({7'h0, ack}, 8'h01);
    settle();
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    rdchk(A_CON2, 8'h40);
    rdchk(A_EVT, 8'h01);
    i_mst.stop();
    settle();
    rd(A_STAT, v);
    chk({3'h0, v[4:3], 3'h0}, 8'h10);
    // Master pulls SDA low against a released one bit
    i_mst.start();
    i_mst.xfer(8'h55, 1'b1, rx, ack);
    rd(A_EVT, v);
    wr(A_BUF, 8'hff);
    wr(A_CON1, 8'h10);
    i_mst.xfer(8'h00, 1'b1, rx, ack);
    settle();
    rd(A_EVT, v);
    chk(v & 8'h02, 8'h02);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    wr(A_CON3, 8'h04);
    wr(A_CON2, 8'h80);
    i_mst.start();
    i_mst.xfer(8'h00, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h01);
    rdchk(A_EVT, 8'h04);
    wr(A_CON2, 8'h00);
    i_mst.start();
    i_mst.xfer(8'h00, 1'b1, rx, ack);
    rdchk(A_EVT, 8'h00);
    // Reset while stretching must let go of SCL at once
    i_mst.start();
    i_mst.xfer(8'h55, 1'b1, rx, ack);
    settle();
    chk({7'h0, scl_oe_n}, 8'h00);
    reset_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    repeat (9) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    rdchk(A_STAT, 8'h00);
    chk({6'h0, scl_o, sda_o}, 8'h00);
    i_mst.stop();
    final_report();
  end
endmodule // i2c_slave_transmit_tb
